// ===== hw/parallel_programming_port.sv
// What this block does, and what the programmer must do
// RL1 - programmer holds each strobe at least 250 ns
// RL2 - write or read strobe runs loaded command; here reads run without the read strobe, which only enables the bus
// RL3 - ready_busy_n low while an operation runs
// RL4 - data bus driven only while read strobe low
// RL5 - byte selects choose low, high, second high
// RL6 - action 00 loads address, 01 loads data
// RL7 - action 10 loads command, 11 does nothing
// RL8 - decode erase, fuse, lock, flash, eeprom writes
// RL9 - decode signature, fuse, flash, eeprom reads
// RL10 - entry needs six clock toggles, pins 0000
// RL11 - entry pins static 100 ns after high voltage
// RL12 - programmer may use alternate entry for clocks
// RL13 - command and address kept across operations
// RL14 - programmer reloads high address per window
// RL15 - erase clears memories, then lock bits last
// RL16 - eeprom kept on erase when fuse says
// RL17 - programmer erases before reprogramming memories
// RL18 - write strobe starts erase, busy until done
// RL19 - flash words collected, whole page programmed
// RL20 - page latch stores data word at address
// RL21 - low address bits pick word, upper page
// RL22 - programmer loads high address with 00, select 1
// RL23 - write strobe with select 0 programs page
// RL24 - 64 word page, word bits 5..0
// RL25 - no-operation command blocks further writes
// RL26 - bus captured on load clock rising edge
module parallel_programming_port
  import pp_port_pkg::*;
#(
  parameter int FLASH_WORDS = FLASH_PAGE_WORDS,
  parameter int EEPROM_BYTES = EEPROM_PAGE_BYTES,
  parameter int GUARD_CYC = ENTRY_GUARD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode entry
  input wire logic reset_pin_low,
  input wire logic hv_on_reset,
  // programming strobes and selects
  input wire logic load_clock_pin,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic page_latch_strobe,
  input wire logic load_action_sel0,
  input wire logic load_action_sel1,
  input wire logic byte_select_hi,
  input wire logic byte_select_ext,
  // data bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // status
  output logic ready_busy_n,
  output logic prog_mode,
  // fuse and lock state
  input wire logic keep_eeprom_on_erase,
  input wire logic [7:0] fuse_lo_in,
  input wire logic [7:0] fuse_hi_in,
  input wire logic [7:0] lock_in,
  // memory read
  output logic [15:0] rd_addr,
  output rd_space_t rd_space,
  input wire logic [15:0] rd_word,
  // memory operations
  output logic nvm_start,
  output nvm_op_t nvm_op,
  output logic [7:0] nvm_wbyte,
  output logic nvm_keep_eeprom,
  input wire logic nvm_done,
  // page word stream
  output logic nvm_word_valid,
  input wire logic nvm_word_ready,
  output logic [15:0] nvm_word_addr,
  output logic [15:0] nvm_word_data
);
  localparam int PW = (FLASH_WORDS > 1) ? $clog2(FLASH_WORDS) : 1;
  localparam int EW = (EEPROM_BYTES > 1) ? $clog2(EEPROM_BYTES) : 1;

  generate
    if (FLASH_WORDS < 2 || FLASH_WORDS > 256 || (FLASH_WORDS & (FLASH_WORDS - 1)) != 0 ||
        EEPROM_BYTES < 2 || EEPROM_BYTES >= FLASH_WORDS || (EEPROM_BYTES & (EEPROM_BYTES - 1)) != 0 ||
        GUARD_CYC < 1 || GUARD_CYC > 255) begin : g_bad_param
      $error("parallel_programming_port: page sizes or guard count out of range");
    end
  endgenerate

  // write decoding shared by the sequencer and its checks, read decoding for the read path
  function automatic nvm_op_t write_op(input logic [7:0] cmd, input logic hi);
    nvm_op_t op;
    op = OP_NONE;
    if (cmd == CMD_CHIP_ERASE) op = OP_ERASE_MEM; // RL8
    else if (cmd == CMD_WRITE_FLASH) op = hi ? OP_NONE : OP_WRITE_FLASH; // RL8 RL23
    else if (cmd == CMD_WRITE_EEPROM) op = hi ? OP_NONE : OP_WRITE_EEPROM; // RL8
    else if (cmd == CMD_WRITE_FUSE) op = hi ? OP_FUSE_HI : OP_FUSE_LO; // RL8 RL5
    else if (cmd == CMD_WRITE_LOCK) op = OP_WRITE_LOCK; // RL8
    return op;
  endfunction

  function automatic rd_space_t read_space(input logic [7:0] cmd);
    rd_space_t sp;
    sp = RD_NONE;
    if (cmd == CMD_READ_FLASH) sp = RD_FLASH; // RL9
    else if (cmd == CMD_READ_EEPROM) sp = RD_EEPROM; // RL9
    else if (cmd == CMD_READ_SIG) sp = RD_SIG; // RL9
    else if (cmd == CMD_READ_FUSE_LOCK) sp = RD_FUSE; // RL9
    return sp;
  endfunction

  // edge detection; pins are synchronous, so one flop each is enough
  logic xtal_q_ff;
  logic wr_q_ff;
  logic pl_q_ff;
  logic hv_q_ff;
  logic xtal_rise;
  logic wr_fall;
  logic pl_rise;
  logic hv_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xtal_q_ff <= 1'b0;
      wr_q_ff <= 1'b1;
      pl_q_ff <= 1'b0;
      hv_q_ff <= 1'b0;
    end else begin
      xtal_q_ff <= load_clock_pin;
      wr_q_ff <= wr_n;
      pl_q_ff <= page_latch_strobe;
      hv_q_ff <= hv_on_reset;
    end
  end

  assign xtal_rise = load_clock_pin & ~xtal_q_ff;
  assign wr_fall = ~wr_n & wr_q_ff;
  assign pl_rise = page_latch_strobe & ~pl_q_ff;
  assign hv_rise = hv_on_reset & ~hv_q_ff;

  // mode entry
  logic [3:0] entry_pins;
  logic [2:0] toggle_cnt_ff;
  logic arm_ff;
  logic [7:0] guard_cnt_ff;
  logic prog_mode_ff;

  assign entry_pins = {page_latch_strobe, load_action_sel1, load_action_sel0, byte_select_hi};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toggle_cnt_ff <= 3'h0;
    end else if (!reset_pin_low && !hv_on_reset) begin
      toggle_cnt_ff <= 3'h0;
    end else if (reset_pin_low && xtal_rise && toggle_cnt_ff != ENTRY_TOGGLES) begin
      toggle_cnt_ff <= toggle_cnt_ff + 3'h1; // RL10
    end
  end

  // a failed entry stays failed until the high voltage is removed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arm_ff <= 1'b0;
      guard_cnt_ff <= 8'h00;
      prog_mode_ff <= 1'b0;
    end else if (!hv_on_reset) begin
      arm_ff <= 1'b0;
      prog_mode_ff <= 1'b0;
    end else if (hv_rise) begin
      arm_ff <= (toggle_cnt_ff == ENTRY_TOGGLES) && (entry_pins == ENTRY_PINS_VALUE); // RL10
      guard_cnt_ff <= 8'(GUARD_CYC);
    end else if (arm_ff) begin
      if (entry_pins != ENTRY_PINS_VALUE) begin
        arm_ff <= 1'b0; // RL11
      end else if (guard_cnt_ff == 8'h01) begin
        arm_ff <= 1'b0;
        prog_mode_ff <= 1'b1; // RL11
      end else begin
        guard_cnt_ff <= guard_cnt_ff - 8'h01;
      end
    end
  end

  assign prog_mode = prog_mode_ff;

  // command, address and data loading
  prog_state_t state_ff;
  logic active;
  logic [7:0] cmd_ff;
  logic [15:0] addr_ff;
  logic [7:0] data_lo_ff;
  logic [7:0] data_hi_ff;

  // loads are refused while busy so the page address cannot move under a stream
  assign active = prog_mode_ff && (state_ff == ST_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_ff <= CMD_NOP;
      addr_ff <= ADDR_RESET;
      data_lo_ff <= DATA_RESET;
      data_hi_ff <= DATA_RESET;
    end else if (!prog_mode_ff) begin
      cmd_ff <= CMD_NOP;
    end else if (active && xtal_rise) begin // RL26 RL13
      case ({load_action_sel1, load_action_sel0})
        ACT_LOAD_ADDR: begin
          if (byte_select_hi) addr_ff[15:8] <= data_in; // RL6 RL5
          else addr_ff[7:0] <= data_in; // RL6
        end
        ACT_LOAD_DATA: begin
          if (byte_select_hi) data_hi_ff <= data_in; // RL6 RL5
          else data_lo_ff <= data_in; // RL6
        end
        ACT_LOAD_CMD: cmd_ff <= data_in; // RL7 RL25
        default: ; // RL7
      endcase
    end
  end

  // page buffer shared by flash words and eeprom bytes
  logic [15:0] page_mem [FLASH_WORDS];

  always_ff @(posedge clk) begin
    if (active && pl_rise) begin
      if (cmd_ff == CMD_WRITE_FLASH) begin
        page_mem[addr_ff[PW-1:0]] <= {data_hi_ff, data_lo_ff}; // RL20 RL21 RL24
      end else if (cmd_ff == CMD_WRITE_EEPROM) begin
        page_mem[{{(PW-EW){1'b0}}, addr_ff[EW-1:0]}] <= {8'h00, data_lo_ff}; // RL20
      end
    end
  end

  // operation sequencer
  logic [PW-1:0] idx_ff;
  logic [PW-1:0] last_ff;
  logic [15:0] mask_ff;
  logic [15:0] base_ff;
  logic nvm_start_ff;
  nvm_op_t nvm_op_ff;
  logic keep_ff;
  logic erase_mem_done_ff;
  nvm_op_t wr_op;

  stream_if #(.WIDTH(STREAM_W)) sbuf();

  assign wr_op = write_op(cmd_ff, byte_select_hi);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      idx_ff <= '0;
      last_ff <= '0;
      mask_ff <= 16'h0000;
      base_ff <= 16'h0000;
      nvm_start_ff <= 1'b0;
      nvm_op_ff <= OP_NONE;
      keep_ff <= 1'b0;
      erase_mem_done_ff <= 1'b0;
    end else begin
      nvm_start_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          erase_mem_done_ff <= 1'b0;
          if (prog_mode_ff && wr_fall) begin // RL2
            case (wr_op)
              OP_NONE: ; // RL25
              OP_ERASE_MEM: begin
                state_ff <= ST_ERASE_MEM; // RL18
                nvm_op_ff <= OP_ERASE_MEM; // RL15
                nvm_start_ff <= 1'b1;
                keep_ff <= keep_eeprom_on_erase; // RL16
              end
              OP_WRITE_FLASH: begin
                state_ff <= ST_STREAM; // RL19 RL23
                nvm_op_ff <= OP_WRITE_FLASH;
                idx_ff <= '0;
                last_ff <= PW'(FLASH_WORDS - 1);
                mask_ff <= 16'(FLASH_WORDS - 1); // RL24
                base_ff <= addr_ff & ~16'(FLASH_WORDS - 1); // RL21
              end
              OP_WRITE_EEPROM: begin
                state_ff <= ST_STREAM;
                nvm_op_ff <= OP_WRITE_EEPROM;
                idx_ff <= '0;
                last_ff <= PW'(EEPROM_BYTES - 1);
                mask_ff <= 16'(EEPROM_BYTES - 1);
                base_ff <= addr_ff & ~16'(EEPROM_BYTES - 1); // RL21
              end
              default: begin
                state_ff <= ST_WAIT; // RL2
                nvm_op_ff <= wr_op;
                nvm_start_ff <= 1'b1;
              end
            endcase
          end
        end
        ST_STREAM: begin
          if (sbuf.in_ready) begin
            idx_ff <= idx_ff + PW'(1);
            if (idx_ff == last_ff) state_ff <= ST_COMMIT; // RL19
          end
        end
        ST_COMMIT: begin
          // program only after every buffered word has reached the array side
          if (sbuf.empty) begin
            nvm_start_ff <= 1'b1; // RL19
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (nvm_done) state_ff <= ST_IDLE; // RL3 RL23
        end
        ST_ERASE_MEM: begin
          if (nvm_done) begin
            erase_mem_done_ff <= 1'b1;
            nvm_op_ff <= OP_CLEAR_LOCK; // RL15
            nvm_start_ff <= 1'b1;
            state_ff <= ST_ERASE_LOCK;
          end
        end
        ST_ERASE_LOCK: begin
          if (nvm_done) state_ff <= ST_IDLE; // RL18
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign ready_busy_n = (state_ff == ST_IDLE); // RL3
  assign nvm_start = nvm_start_ff;
  assign nvm_op = nvm_op_ff;
  assign nvm_wbyte = data_lo_ff;
  assign nvm_keep_eeprom = keep_ff; // RL16

  // the buffer absorbs a stall by the array side without losing a word
  assign sbuf.in_valid = (state_ff == ST_STREAM);
  assign sbuf.in_data = {base_ff | (16'(idx_ff) & mask_ff), page_mem[idx_ff]}; // RL21 RL24
  assign sbuf.out_ready = nvm_word_ready;
  assign nvm_word_valid = sbuf.out_valid;
  assign nvm_word_addr = sbuf.out_data[31:16];
  assign nvm_word_data = sbuf.out_data[15:0];

  pp_word_buffer #(.WIDTH(STREAM_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .port(sbuf.store)
  );

  // read path; data lags the selects by one cycle
  logic [7:0] data_out_ff;
  logic [15:0] rd_addr_ff;
  rd_space_t rd_space_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_addr_ff <= ADDR_RESET;
      rd_space_ff <= RD_NONE;
    end else begin
      rd_addr_ff <= addr_ff;
      rd_space_ff <= prog_mode_ff ? read_space(cmd_ff) : RD_NONE; // RL9 RL13
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out_ff <= DATA_RESET;
    end else begin
      case (cmd_ff)
        CMD_READ_FLASH, CMD_READ_SIG: data_out_ff <= byte_select_hi ? rd_word[15:8] : rd_word[7:0]; // RL5 RL9
        CMD_READ_EEPROM: data_out_ff <= rd_word[7:0]; // RL9
        CMD_READ_FUSE_LOCK: begin
          case ({byte_select_ext, byte_select_hi})
            2'h0: data_out_ff <= fuse_lo_in; // RL5
            2'h3: data_out_ff <= fuse_hi_in; // RL5
            2'h1: data_out_ff <= lock_in;
            default: data_out_ff <= DATA_RESET;
          endcase
        end
        default: data_out_ff <= DATA_RESET;
      endcase
    end
  end

  assign rd_addr = rd_addr_ff;
  assign rd_space = rd_space_ff;
  assign data_out = data_out_ff;
  assign data_oe = prog_mode_ff & ~oe_n; // RL4

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_busy_on_start: assert property ( // RL18
    active && wr_fall && write_op(cmd_ff, byte_select_hi) != OP_NONE |=> !ready_busy_n)
    else $error("write strobe did not raise busy");
  chk_ready_after_done: assert property ( // RL3
    state_ff == ST_WAIT && nvm_done |=> ready_busy_n && !nvm_start)
    else $error("ready not restored after operation end");
  chk_nop_no_write: assert property ( // RL25
    active && wr_fall && cmd_ff == CMD_NOP |=> ready_busy_n && !nvm_start ##1 ready_busy_n)
    else $error("write started under no-operation command");
  chk_cmd_load: assert property ( // RL7
    active && xtal_rise && {load_action_sel1, load_action_sel0} == ACT_LOAD_CMD |=> cmd_ff == $past(data_in))
    else $error("command byte not loaded");
  chk_idle_action: assert property ( // RL7
    active && xtal_rise && {load_action_sel1, load_action_sel0} == ACT_IDLE
    |=> $stable(cmd_ff) && $stable(addr_ff) && $stable(data_lo_ff) && $stable(data_hi_ff))
    else $error("idle action changed a register");
  chk_addr_high: assert property ( // RL6
    active && xtal_rise && {load_action_sel1, load_action_sel0} == ACT_LOAD_ADDR && byte_select_hi
    |=> addr_ff[15:8] == $past(data_in) && $stable(addr_ff[7:0]))
    else $error("address high byte not loaded");
  chk_data_low: assert property ( // RL6
    active && xtal_rise && {load_action_sel1, load_action_sel0} == ACT_LOAD_DATA && !byte_select_hi
    |=> data_lo_ff == $past(data_in) && $stable(data_hi_ff))
    else $error("data low byte not loaded");
  chk_page_latch: assert property ( // RL20
    active && pl_rise && cmd_ff == CMD_WRITE_FLASH
    |=> page_mem[$past(addr_ff[PW-1:0])] == {$past(data_hi_ff), $past(data_lo_ff)})
    else $error("page latch stored wrong word");
  chk_lock_after_erase: assert property ( // RL15
    nvm_start && nvm_op == OP_CLEAR_LOCK |-> erase_mem_done_ff && $past(state_ff) == ST_ERASE_MEM)
    else $error("lock bits cleared before memory erase finished");
  chk_keep_eeprom: assert property ( // RL16
    nvm_start && nvm_op == OP_ERASE_MEM |-> nvm_keep_eeprom == $past(keep_eeprom_on_erase))
    else $error("eeprom keep flag not passed to erase");
  chk_bus_release: assert property ( // RL4
    $rose(oe_n) |-> !data_oe)
    else $error("bus still driven after read strobe rose");
  chk_entry_static: assert property ( // RL11
    $rose(prog_mode_ff) |-> $past(entry_pins == ENTRY_PINS_VALUE, 1) && $past(entry_pins == ENTRY_PINS_VALUE, 2))
    else $error("mode entered with moving entry pins");
  chk_stream_addr: assert property ( // RL24
    sbuf.in_valid && nvm_op_ff == OP_WRITE_FLASH
    |-> sbuf.in_data[16+PW-1:16] == idx_ff && sbuf.in_data[31:16+PW] == addr_ff[15:PW])
    else $error("page word address wrong");

  cov_entry: cover property ($rose(prog_mode_ff));
  cov_erase_done: cover property (state_ff == ST_ERASE_LOCK && nvm_done);
  cov_page_stall: cover property (sbuf.out_valid && !nvm_word_ready ##1 state_ff == ST_COMMIT);
  cov_read_drive: cover property (data_oe && cmd_ff == CMD_READ_FLASH && byte_select_hi);
endmodule

// ===== hw/pp_port_pkg.sv
package pp_port_pkg;

  // command bytes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
  localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
  localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
  localparam logic [7:0] CMD_READ_SIG = 8'h08;
  localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
  localparam logic [7:0] CMD_READ_FLASH = 8'h02;
  localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

  // action codes on the two action select pins
  localparam logic [1:0] ACT_LOAD_ADDR = 2'h0;
  localparam logic [1:0] ACT_LOAD_DATA = 2'h1;
  localparam logic [1:0] ACT_LOAD_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // mode entry
  localparam logic [3:0] ENTRY_PINS_VALUE = 4'h0;
  localparam logic [2:0] ENTRY_TOGGLES = 3'h6;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int STROBE_MIN_NS = 250;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENTRY_GUARD_NS = 100;
  localparam int ENTRY_GUARD_CYC_RAW = (ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENTRY_GUARD_CYC = (ENTRY_GUARD_CYC_RAW < 1) ? 1 : ENTRY_GUARD_CYC_RAW;

  // memory organisation
  localparam int FLASH_PAGE_WORDS = 64;
  localparam int EEPROM_PAGE_BYTES = 4;
  localparam int STREAM_W = 32;
  localparam int BUF_DEPTH = 2;

  // reset values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_STREAM = 3'h1,
    ST_COMMIT = 3'h3,
    ST_WAIT = 3'h2,
    ST_ERASE_MEM = 3'h6,
    ST_ERASE_LOCK = 3'h4
  } prog_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ERASE_MEM = 3'h1,
    OP_CLEAR_LOCK = 3'h2,
    OP_WRITE_FLASH = 3'h3,
    OP_WRITE_EEPROM = 3'h4,
    OP_FUSE_LO = 3'h5,
    OP_FUSE_HI = 3'h6,
    OP_WRITE_LOCK = 3'h7
  } nvm_op_t;

  typedef enum logic [2:0] {
    RD_NONE = 3'h0,
    RD_FLASH = 3'h1,
    RD_EEPROM = 3'h2,
    RD_SIG = 3'h3,
    RD_FUSE = 3'h4
  } rd_space_t;

endpackage

// ===== hw/stream_if.sv
interface stream_if #(parameter int WIDTH = 32);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic empty;

  modport fill(output in_valid, output in_data, output out_ready,
               input in_ready, input out_valid, input out_data, input empty);
  modport store(input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data, output empty);
endinterface

// ===== hw/pp_word_buffer.sv
module pp_word_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // buffered stream
  stream_if.store port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("pp_word_buffer: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign port.in_ready = (count_ff != (AW+1)'(DEPTH));
  assign port.out_valid = (count_ff != '0);
  assign port.empty = (count_ff == '0);
  assign port.out_data = mem[rd_ptr_ff];
  assign push = port.in_valid & port.in_ready;
  assign pop = port.out_valid & port.out_ready;

  // storage needs no reset, only pointers and count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= port.in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (pop) rd_ptr_ff <= rd_ptr_ff + AW'(1);
      if (push && !pop) count_ff <= count_ff + (AW+1)'(1);
      else if (pop && !push) count_ff <= count_ff - (AW+1)'(1);
    end
  end
endmodule

// ===== testbench/nvm_model.sv
module nvm_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operation handshake
  input wire logic start,
  output logic done,
  // page word stream
  output logic word_ready,
  // read port
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_ff;
  logic busy_ff;
  logic [1:0] stall_ff;
  // scrambled address as content, so a stale or wrong address shows
  assign rd_word = rd_addr ^ 16'hA55A;
  // refuses one cycle in four, so the buffer has to hold words back
  assign word_ready = (stall_ff != 2'h0);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_ff <= 3'h0;
      busy_ff <= 1'b0;
      stall_ff <= 2'h0;
      done <= 1'b0;
    end else begin
      stall_ff <= stall_ff + 2'h1;
      done <= busy_ff && !start && (wait_ff == 3'h0);
      if (start) begin
        busy_ff <= 1'b1;
        // answer time varies from 4 to 7 cycles
        wait_ff <= 3'h3 + {1'b0, stall_ff};
      end else if (busy_ff && wait_ff == 3'h0) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 3'h1;
      end
    end
  end
endmodule

// ===== testbench/tb.sv
module tb
  import pp_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_low = 1'b0;
  logic hv_on_reset = 1'b0;
  logic load_clock_pin = 1'b0;
  logic wr_n = 1'b1;
  logic oe_n = 1'b1;
  logic page_latch_strobe = 1'b0;
  logic load_action_sel0 = 1'b1;
  logic load_action_sel1 = 1'b1;
  logic byte_select_hi = 1'b0;
  logic byte_select_ext = 1'b0;
  logic keep_eeprom_on_erase = 1'b0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out, nvm_wbyte;
  logic data_oe, ready_busy_n, prog_mode, nvm_start, nvm_keep_eeprom, nvm_done;
  logic nvm_word_valid, nvm_word_ready;
  logic [15:0] rd_addr, rd_word, nvm_word_addr, nvm_word_data;
  logic [31:0] last_word;
  rd_space_t rd_space;
  nvm_op_t nvm_op;
  nvm_op_t ops[$];
  int n_words = 0;
  int n_errors = 0;
  int n_checks = 0;

  parallel_programming_port u_parallel_programming_port (
    .clk(clk), .rst_n(rst_n), .reset_pin_low(reset_pin_low), .hv_on_reset(hv_on_reset),
    .load_clock_pin(load_clock_pin), .wr_n(wr_n), .oe_n(oe_n), .page_latch_strobe(page_latch_strobe),
    .load_action_sel0(load_action_sel0), .load_action_sel1(load_action_sel1),
    .byte_select_hi(byte_select_hi), .byte_select_ext(byte_select_ext), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ready_busy_n(ready_busy_n), .prog_mode(prog_mode),
    .keep_eeprom_on_erase(keep_eeprom_on_erase), .fuse_lo_in(8'hF1), .fuse_hi_in(8'hD9),
    .lock_in(8'hFC), .rd_addr(rd_addr), .rd_space(rd_space), .rd_word(rd_word),
    .nvm_start(nvm_start), .nvm_op(nvm_op), .nvm_wbyte(nvm_wbyte), .nvm_keep_eeprom(nvm_keep_eeprom),
    .nvm_done(nvm_done), .nvm_word_valid(nvm_word_valid), .nvm_word_ready(nvm_word_ready),
    .nvm_word_addr(nvm_word_addr), .nvm_word_data(nvm_word_data));
  nvm_model u_nvm_model (.clk(clk), .rst_n(rst_n), .start(nvm_start), .done(nvm_done),
    .word_ready(nvm_word_ready), .rd_addr(rd_addr), .rd_word(rd_word));

  always #50 clk = ~clk;

  // mid-cycle sampling keeps clear of the edge that launches these
  always @(negedge clk) begin
    if (nvm_start === 1'b1) ops.push_back(nvm_op);
    if (nvm_word_valid === 1'b1 && nvm_word_ready === 1'b1) begin
      n_words++;
      last_word = {nvm_word_addr, nvm_word_data};
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic enter(input logic bad, input logic late);
    @(posedge clk);
    reset_pin_low <= 1'b1;
    // action selects double as entry pins, so they must read 00 here
    {load_action_sel1, load_action_sel0} <= 2'h0;
    repeat (6) begin
      @(posedge clk);
      load_clock_pin <= 1'b1;
      repeat (3) @(posedge clk);
      load_clock_pin <= 1'b0;
    end
    @(posedge clk);
    reset_pin_low <= 1'b0;
    hv_on_reset <= 1'b1;
    byte_select_hi <= bad & ~late;
    @(posedge clk);
    // a late move lands inside the guard time after the high voltage
    byte_select_hi <= bad;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(prog_mode), 32'(!bad));
    @(posedge clk);
    hv_on_reset <= !bad;
    byte_select_hi <= 1'b0;
  endtask

  task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
    @(posedge clk);
    {load_action_sel1, load_action_sel0} <= a;
    byte_select_hi <= b;
    data_in <= d;
    @(posedge clk);
    load_clock_pin <= 1'b1;
    repeat (3) @(posedge clk);
    load_clock_pin <= 1'b0;
  endtask

  task automatic wrp(input logic b, input logic busy);
    @(posedge clk);
    byte_select_hi <= b;
    wr_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(ready_busy_n), 32'(!busy));
    @(posedge clk);
    wr_n <= 1'b1;
    // bounded wait for ready before any further command
    for (int i = 0; i < 500 && ready_busy_n !== 1'b1; i++) @(posedge clk);
    #1;
    chk(32'(ready_busy_n), 32'h1);
  endtask

  task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
    @(posedge clk);
    {byte_select_ext, byte_select_hi} <= sel;
    oe_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(data_oe), 32'h1);
    chk(32'(data_out), 32'(exp));
  endtask

  task automatic reads;
    logic [7:0] fz[4];
    fz = '{8'hF1, 8'hFC, 8'h00, 8'hD9};
    ld(ACT_LOAD_CMD, 1'b0, CMD_READ_FLASH);
    ld(ACT_LOAD_ADDR, 1'b1, 8'h12);
    ld(ACT_LOAD_ADDR, 1'b0, 8'h34);
    ld(ACT_IDLE, 1'b0, 8'h77);
    rd(2'h0, 8'h6E);
    rd(2'h1, 8'hB7);
    chk(32'(rd_space), 32'(RD_FLASH));
    chk(32'(rd_addr), 32'h1234);
    ld(ACT_LOAD_CMD, 1'b0, CMD_READ_EEPROM);
    rd(2'h1, 8'h6E);
    ld(ACT_LOAD_CMD, 1'b0, CMD_READ_FUSE_LOCK);
    for (int k = 0; k < 4; k++) rd(2'(k), fz[k]);
    @(posedge clk);
    oe_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'(data_oe), 32'h0);
  endtask

  task automatic wr_ops;
    ops.delete();
    ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_FUSE);
    ld(ACT_LOAD_DATA, 1'b0, 8'h5A);
    wrp(1'b0, 1'b1);
    wrp(1'b1, 1'b1);
    chk(32'(nvm_wbyte), 32'h5A);
    ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_LOCK);
    wrp(1'b0, 1'b1);
    ld(ACT_LOAD_CMD, 1'b0, CMD_WRITE_FLASH);
    wrp(1'b1, 1'b0);
    ld(ACT_LOAD_CMD, 1'b0, CMD_NOP);
    wrp(1'b0, 1'b0);
    chk(32'(ops.size()), 32'h3);
    chk(32'({ops[0], ops[1], ops[2]}), 32'({OP_FUSE_LO, OP_FUSE_HI, OP_WRITE_LOCK}));
  endtask

  task automatic erase;
    ops.delete();
    @(posedge clk);
    keep_eeprom_on_erase <= 1'b1;
    ld(ACT_LOAD_CMD, 1'b0, CMD_CHIP_ERASE);
    wrp(1'b0, 1'b1);
    chk(32'(nvm_keep_eeprom), 32'h1);
    chk(32'({ops[0], ops[1]}), 32'({OP_ERASE_MEM, OP_CLEAR_LOCK}));
  endtask

  task automatic page(input logic [7:0] cmd, input int n, input logic [15:0] last, input nvm_op_t op);
    int base;
    base = n_words;
    ops.delete();
    ld(ACT_LOAD_CMD, 1'b0, cmd);
    ld(ACT_LOAD_ADDR, 1'b1, 8'h01);
    for (int i = 0; i < n; i++) begin
      ld(ACT_LOAD_ADDR, 1'b0, 8'h80 | 8'(i));
      ld(ACT_LOAD_DATA, 1'b0, 8'(i));
      ld(ACT_LOAD_DATA, 1'b1, 8'hC0 | 8'(i));
      @(posedge clk);
      page_latch_strobe <= 1'b1;
      repeat (3) @(posedge clk);
      page_latch_strobe <= 1'b0;
    end
    wrp(1'b0, 1'b1);
    chk(32'(n_words - base), 32'(n));
    chk(last_word, {16'h0180 + 16'(n - 1), last});
    chk(32'(ops[0]), 32'(op));
  endtask

  // about six times the expected run length
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    enter(1'b1, 1'b0);
    enter(1'b1, 1'b1);
    enter(1'b0, 1'b0);
    reads();
    wr_ops();
    erase();
    page(CMD_WRITE_FLASH, 64, 16'hFF3F, OP_WRITE_FLASH);
    page(CMD_WRITE_EEPROM, 4, 16'h0003, OP_WRITE_EEPROM);
    tally_and_finish();
  end
endmodule
